// ### design/ahsr_arbiter.sv
// Bus arbiter with split masking, default master fallback and master tag broadcast.
`timescale 1ns/100ps
`include "ahsr_regs.svh"
module ahsr_arbiter
    import ahsr_pkg::*;
#(
    parameter int NUM_MASTERS    = 16,
    parameter int DEFAULT_MASTER = 0,
    parameter int NUM_SPLITTERS  = 1
) (
    // Clock and asynchronous active low reset.
    input  wire logic                                     clock,
    input  wire logic                                     nrst,
    // Master requests and grants.
    input  wire logic [NUM_MASTERS-1:0]                   hbusreq,
    output wire logic [NUM_MASTERS-1:0]                   hgrant,
    output wire logic [`AHSR_TAG_W-1:0]                   hmaster,
    // Shared response from the selected slave.
    input  wire logic                                     hready,
    input  wire logic [`AHSR_RESP_W-1:0]                  hresp,
    // Resume buses, one 16-bit group per split-capable slave.
    input  wire logic [NUM_SPLITTERS*`AHSR_MAX_MASTERS-1:0] hsplit_in
);
    localparam ahsr_vec_t DEFAULT_ONEHOT = `AHSR_ONE_HOT_LSB << DEFAULT_MASTER;

    logic            rst_meta_q;
    logic            rst_n;
    ahsr_arb_state_t st_q;
    ahsr_arb_state_t st_d;
    ahsr_vec_t       req16;
    ahsr_vec_t       elig;
    ahsr_vec_t       elig_low;
    ahsr_vec_t       mask_next;
    ahsr_vec_t       resume;
    ahsr_vec_t       resume_or [NUM_SPLITTERS+1];
    logic            split_first;

    ahsr_split_if sif ();

    function automatic ahsr_tag_t onehot_to_tag(input ahsr_vec_t v);
        ahsr_tag_t t;
        t = `AHSR_TAG_RST;
        for (int i = 0; i < `AHSR_MAX_MASTERS; i++) begin
            if (v[i]) begin
                t = ahsr_tag_t'(i);
            end
        end
        return t;
    endfunction : onehot_to_tag

    // Reset asserts at once and releases on a clock edge after two stages.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // Requests widened to the full master space; unused masters never request.
    genvar gi;
    generate
        for (gi = 0; gi < `AHSR_MAX_MASTERS; gi++) begin : g_req
            if (gi < NUM_MASTERS) begin : g_used
                assign req16[gi] = hbusreq[gi];
            end else begin : g_unused
                assign req16[gi] = 1'b0;
            end
        end
    endgenerate

    // Resume buses from every split-capable slave merge into one.
    assign resume_or[0] = `AHSR_MASK_RST;
    generate
        for (gi = 0; gi < NUM_SPLITTERS; gi++) begin : g_split
            assign resume_or[gi+1] = resume_or[gi] | hsplit_in[gi*`AHSR_MAX_MASTERS +: `AHSR_MAX_MASTERS];
        end
    endgenerate
    assign resume = resume_or[NUM_SPLITTERS];

    // The first SPLIT cycle is the one with the response shown and ready still low.
    assign split_first = (hresp == `AHSR_RESP_SPLIT) && !hready;

    assign sif.split_first = split_first;
    assign sif.data_master = st_q.data_master;
    assign sif.resume      = resume;

    ahsr_split_mask u_mask (
        .clock (clock),
        .rst_n (rst_n),
        .sif   (sif.trk)
    );

    // Arbitration looks at the mask as it will stand after this edge, so the
    // split master loses the grant on the very edge that samples the response, unless it is the default master and no other master is eligible.
    always_comb begin
        mask_next = (sif.mask & ~resume);
        if (split_first) begin
            mask_next = mask_next | (`AHSR_ONE_HOT_LSB << st_q.data_master);
        end
        elig     = req16 & ~mask_next;
        elig_low = elig & (~elig + `AHSR_ONE_HOT_LSB);
        st_d = st_q;
        if (elig != `AHSR_MASK_RST) begin
            st_d.grant = elig_low;
        end else begin
            st_d.grant = DEFAULT_ONEHOT;
        end
        // The tag follows the grant once the current transfer completes.
        if (hready) begin
            st_d.hmaster     = onehot_to_tag(st_q.grant);
            st_d.data_master = st_q.hmaster;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q.grant       <= DEFAULT_ONEHOT;
            st_q.hmaster     <= ahsr_tag_t'(DEFAULT_MASTER);
            st_q.data_master <= ahsr_tag_t'(DEFAULT_MASTER);
        end else begin
            st_q <= st_d;
        end
    end

    assign hgrant  = st_q.grant[NUM_MASTERS-1:0];
    assign hmaster = st_q.hmaster;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    grant_onehot_a: assert property ($onehot(st_q.grant))
        else $error("grant is not one-hot");
    default_grant_a: assert property ((elig == `AHSR_MASK_RST) |=> st_q.grant == DEFAULT_ONEHOT)
        else $error("default master not granted");
    split_handover_a: assert property ((split_first && st_q.data_master != ahsr_tag_t'(DEFAULT_MASTER))
                                       |=> !st_q.grant[$past(st_q.data_master)])
        else $error("split master kept the grant");
    masked_no_grant_a: assert property (((st_q.grant & sif.mask & ~DEFAULT_ONEHOT)) == `AHSR_MASK_RST)
        else $error("masked master granted");
    priority_pick_a: assert property ((elig != `AHSR_MASK_RST) |=> st_q.grant == $past(elig_low))
        else $error("wrong master granted");
    tag_follow_a: assert property (hready |=> st_q.hmaster == onehot_to_tag($past(st_q.grant)))
        else $error("tag did not follow grant");
    tag_hold_a: assert property (!hready |=> $stable(st_q.hmaster) && $stable(st_q.data_master))
        else $error("tag changed during wait state");
    resume_regrant_a: assert property ((resume[1] && req16[1] && !req16[0] && !split_first)
                                       |=> st_q.grant[1])
        else $error("resumed top master not regranted");
    split_data_tag_a: assert property ((split_first ##1 hready) |=> st_q.data_master == $past(st_q.hmaster, 1))
        else $error("data phase owner wrong after split");
    reset_sync_a: assert property ($rose(rst_n) |-> $past(nrst, 2))
        else $error("reset released without two clean edges");
    reset_grant_a: assert property ($rose(rst_n) |-> st_q.grant == DEFAULT_ONEHOT)
        else $error("default master not granted after reset");

    // Per-master checks on the priority pick and on the split masks.
    generate
        for (gi = 0; gi < `AHSR_MAX_MASTERS; gi++) begin : g_chk
            localparam ahsr_vec_t ABOVE = (`AHSR_ONE_HOT_LSB << gi) - `AHSR_ONE_HOT_LSB;
            regrant_top_a: assert property (@(posedge clock) disable iff (!rst_n)
                (resume[gi] && req16[gi] && !split_first && ((elig & ABOVE) == `AHSR_MASK_RST))
                |=> st_q.grant[gi])
                else $error("resumed master passed over");
            mask_stand_a: assert property (@(posedge clock) disable iff (!rst_n)
                (sif.mask[gi] && !resume[gi]) |=> sif.mask[gi])
                else $error("split mask dropped without resume");
            grant_req_a: assert property (@(posedge clock) disable iff (!rst_n)
                (st_q.grant[gi] && !DEFAULT_ONEHOT[gi]) |-> $past(req16[gi]))
                else $error("master granted without request");
        end
    endgenerate
endmodule : ahsr_arbiter

// ### design/ahsr_regs.svh
// Constants for the split and retry aware bus arbiter.
`ifndef AHSR_REGS_SVH
`define AHSR_REGS_SVH
`define AHSR_MAX_MASTERS 16
`define AHSR_TAG_W       4
`define AHSR_RESP_W      2
`define AHSR_RESP_SPLIT  2'h3
`define AHSR_MASK_RST    16'h0000
`define AHSR_TAG_RST     4'h0
`define AHSR_ONE_HOT_LSB 16'h0001
`endif

// ### design/ahsr_pkg.sv
// Types shared by the arbiter and its split mask tracker.
`include "ahsr_regs.svh"
package ahsr_pkg;
    typedef logic [`AHSR_MAX_MASTERS-1:0] ahsr_vec_t;
    typedef logic [`AHSR_TAG_W-1:0]       ahsr_tag_t;

    typedef struct packed {
        ahsr_vec_t grant;
        ahsr_tag_t hmaster;
        ahsr_tag_t data_master;
    } ahsr_arb_state_t;

    typedef struct packed {
        ahsr_vec_t mask;
    } ahsr_trk_state_t;
endpackage : ahsr_pkg

// ### design/ahsr_split_if.sv
// Link between the arbiter core and its split mask tracker.
`timescale 1ns/100ps
interface ahsr_split_if;
    import ahsr_pkg::*;
    logic      split_first;
    ahsr_tag_t data_master;
    ahsr_vec_t resume;
    ahsr_vec_t mask;
    modport arb (output split_first, output data_master, output resume, input mask);
    modport trk (input split_first, input data_master, input resume, output mask);
endinterface : ahsr_split_if

// ### design/ahsr_split_mask.sv
// Per-master split mask flags, set by a SPLIT response and cleared by resume bits.
`timescale 1ns/100ps
`include "ahsr_regs.svh"
module ahsr_split_mask
    import ahsr_pkg::*;
(
    // Clock and synchronised reset.
    input wire logic clock,
    input wire logic rst_n,
    // Arbiter side.
    ahsr_split_if.trk sif
);
    ahsr_trk_state_t st_q;
    ahsr_trk_state_t st_d;
    ahsr_vec_t       set_vec;

    always_comb begin
        set_vec = `AHSR_MASK_RST;
        if (sif.split_first) begin
            set_vec = `AHSR_ONE_HOT_LSB << sif.data_master;
        end
        // A resume pulse is caught in any single cycle; a new split of the same master wins.
        st_d.mask = (st_q.mask & ~sif.resume) | set_vec;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q.mask <= `AHSR_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign sif.mask = st_q.mask;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    mask_set_a: assert property (sif.split_first |=> st_q.mask[$past(sif.data_master)])
        else $error("split master not masked");
    resume_clear_a: assert property (1'b1 |=> ((st_q.mask & $past(sif.resume & ~set_vec)) == `AHSR_MASK_RST))
        else $error("resume bit did not clear mask");
    mask_hold_a: assert property (1'b1 |=> ((st_q.mask & ~$past(st_q.mask) & ~$past(set_vec)) == `AHSR_MASK_RST))
        else $error("mask bit set without split");
    reset_clear_a: assert property ($rose(rst_n) |-> st_q.mask == `AHSR_MASK_RST)
        else $error("mask not clear after reset");
endmodule : ahsr_split_mask

// ### verification/ahsr_slave_model.sv
// Split-capable slave model that answers OKAY, waits, ERROR (2'h1), SPLIT or RETRY and later resumes masters.
`timescale 1ns/100ps
`include "ahsr_regs.svh"
module ahsr_slave_model
    import ahsr_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Bench commands.
    input  wire logic       split_req,
    input  wire logic       stall,
    input  wire logic       resume_go,
    // Bus side.
    input  wire ahsr_tag_t  hmaster,
    output logic            hready,
    output logic [1:0]      hresp,
    output ahsr_vec_t       hsplit
);
    ahsr_vec_t pend;
    ahsr_tag_t owner;
    ahsr_tag_t rtag;
    logic      rbusy;
    logic      second;
    logic      idle_cyc;
    // The master in the data phase from the next edge on.
    wire ahsr_tag_t cur = hready ? hmaster : owner;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hready   <= 1'b1;
            hresp    <= 2'h0;
            hsplit   <= '0;
            pend     <= '0;
            owner    <= '0;
            rtag     <= '0;
            rbusy    <= 1'b0;
            second   <= 1'b0;
            idle_cyc <= 1'b0;
        end else begin
            if (hready)
                owner <= hmaster;
            // All pending masters resume together, so the order of service is left to the arbiter.
            hsplit <= resume_go ? pend : '0;
            // One pending flag per master, as each master has one outstanding transfer at most.
            pend   <= (resume_go ? '0 : pend)
                      | ((second && hresp == `AHSR_RESP_SPLIT) ? ahsr_vec_t'(1) << owner : '0);
            second <= 1'b0;
            // A split or retried master follows with an idle transfer, which never waits.
            idle_cyc <= second && (hresp == 2'h2 || hresp == `AHSR_RESP_SPLIT);
            if (second) begin
                hready <= 1'b1;
            end else if (idle_cyc && hmaster == owner) begin
                hresp  <= 2'h0;
                hready <= 1'b1;
            end else if (split_req && cur != '0) begin
                hready <= 1'b0;
                second <= 1'b1;
                if (!stall) begin
                    hresp <= `AHSR_RESP_SPLIT;
                end else if (rbusy && cur != rtag) begin
                    hresp <= 2'h1;
                end else begin
                    hresp <= 2'h2;
                    rtag  <= cur;
                    rbusy <= 1'b1;
                end
            end else begin
                hresp  <= 2'h0;
                hready <= !stall;
                if (!stall && cur == rtag)
                    rbusy <= 1'b0;
            end
        end
    end
endmodule : ahsr_slave_model

// ### verification/ahsr_split_retry_handling_test.sv
// Random bench comparing the arbiter's grants and tag with a cycle model.
`timescale 1ns/100ps
`include "ahsr_regs.svh"
module ahsr_split_retry_handling_test;
    import ahsr_pkg::*;
    logic       clock;
    logic       nrst;
    ahsr_vec_t  hbusreq;
    wire ahsr_vec_t hgrant;
    wire ahsr_tag_t hmaster;
    wire logic  hready;
    wire logic [1:0] hresp;
    wire ahsr_vec_t hsplit;
    logic       split_req;
    logic       stall;
    logic       resume_go;
    int         n_mismatch;
    int         checks;
    int         rc;
    bit         go;
    ahsr_vec_t  eg;
    ahsr_vec_t  mk;
    ahsr_vec_t  el;
    ahsr_tag_t  em;
    ahsr_tag_t  eo;

    ahsr_arbiter #(.NUM_MASTERS(16), .DEFAULT_MASTER(0), .NUM_SPLITTERS(1)) uut (.clock(clock), .nrst(nrst),
        .hbusreq(hbusreq), .hgrant(hgrant), .hmaster(hmaster), .hready(hready), .hresp(hresp), .hsplit_in(hsplit));
    ahsr_slave_model slave (.clock(clock), .nrst(nrst), .split_req(split_req), .stall(stall),
        .resume_go(resume_go), .hmaster(hmaster), .hready(hready), .hresp(hresp), .hsplit(hsplit));

    function automatic ahsr_tag_t idx(ahsr_vec_t v);
        ahsr_tag_t r = '0;
        for (int i = 0; i < 16; i++)
            if (v[i])
                r = i[3:0];
        return r;
    endfunction : idx

    // Reference model; internal reset ends on the second edge after release.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rc = 0;
            eg = `AHSR_ONE_HOT_LSB;
            mk = '0;
            em = '0;
            eo = '0;
        end else if (rc == 2) begin
            mk = (mk & ~hsplit) | ((hresp == `AHSR_RESP_SPLIT && !hready) ? ahsr_vec_t'(1) << eo : '0);
            if (hready) begin
                eo = em;
                em = idx(eg);
            end
            el = hbusreq & ~mk;
            eg = (el != '0) ? (el & (~el + 1'b1)) : `AHSR_ONE_HOT_LSB;
        end else
            rc++;
    end

    task automatic check_vec(ahsr_vec_t got, ahsr_vec_t exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: grant %h expected %h", $time, got, exp);
        end
    endtask : check_vec

    task automatic check_tag(ahsr_tag_t got, ahsr_tag_t exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: tag %h expected %h", $time, got, exp);
        end
    endtask : check_tag

    always @(negedge clock) begin
        if (go) begin
            check_vec(hgrant, eg);
            check_tag(hmaster, em);
        end
    end

    task automatic run(int n, int rm);
        repeat (n) begin
            @(posedge clock);
            hbusreq   <= ahsr_vec_t'($urandom) & 16'hfffe;
            split_req <= ($urandom % 4) == 0;
            stall     <= ($urandom % 7) == 0;
            resume_go <= rm != 0 && ($urandom % rm) == 0;
        end
    endtask : run

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        #60000;
        n_mismatch++;
        final_report;
    end

    initial begin
        nrst = 1'b0;
        hbusreq = '0;
        split_req = 1'b0;
        stall = 1'b0;
        resume_go = 1'b0;
        n_mismatch = 0;
        checks = 0;
        go = 1'b0;
        void'($urandom(32'h2df1));
        @(posedge clock);
        go <= 1'b1;
        repeat (9) @(posedge clock);
        nrst <= 1'b1;
        $display("test reset done");
        run(400, 0);
        $display("test all split done");
        run(2000, 3);
        $display("test random done");
        @(posedge clock);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        run(800, 2);
        $display("test second reset done");
        final_report;
    end
endmodule : ahsr_split_retry_handling_test
